//--- serial_mux_command_config.sv
`timescale 1ns/1ps
module serial_mux_command_config
  import serial_mux_pkg::*;
#(
  parameter logic [7:0] CARD_KEY = CARD_KEY_DEFAULT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Read-data request toward the receive path
  output logic             read_valid,
  output logic      [2:0]  read_port,
  output logic      [5:0]  read_flags,
  // Write-data request toward the transmit path
  output logic             write_valid,
  output logic      [2:0]  write_port,
  output logic             write_append,
  output logic      [1:0]  write_sep_count,
  output logic      [15:0] write_sep_chars,
  // Control request
  output logic             ctrl_valid,
  output logic      [2:0]  ctrl_port,
  output logic      [3:0]  ctrl_action,
  // Card diagnostic register
  output logic      [7:0]  card_reg
);
  // ==========================================================
  // Bus phases
  logic         addr_phase;
  logic         wr_phase;
  logic [7:0]   wr_addr;
  logic         exec;
  cmd_word_t    cmd;
  logic [31:0]  data_q;
  logic [2:0]   sel_port;
  logic [2:0]   sel_word;
  status_word_t status_q;
  cfg_t         cfg      [NUM_PORTS];
  logic [2:0]   port_map [NUM_PORTS];
  logic [31:0]  rd_value;
  logic [255:0] cfg_bits;
  assign addr_phase = hsel & htrans[1] & hready;
  assign exec       = wr_phase && (wr_addr == OFS_CMD);
  assign cmd        = cmd_word_t'(hwdata);
  // Single word transfers only, so hsize needs no lane steering
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_phase  <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_phase  <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
      wr_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // ==========================================================
  // Logical port lookup
  logic [NUM_PORTS-1:0] id_match;
  logic                 port_hit;
  logic [2:0]           phys;
  cfg_t                 cur_cfg;
  generate
    for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_match
      assign id_match[gp] = (port_map[gp] == cmd.port);
    end
  endgenerate
  always_comb begin
    port_hit = |id_match;
    phys     = 3'h0;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (id_match[i]) begin
        phys = 3'(i);
      end
    end
    cur_cfg = cfg[phys];
  end
  // ==========================================================
  // Request decode
  status_word_t next_status;
  cfg_t         next_cfg;
  logic         cfg_write, map_write, card_write, go_read, go_write, go_ctrl;
  logic [5:0]   base_flags;
  logic [5:0]   next_flags;
  assign base_flags = {cur_cfg.char_hs_en, cur_cfg.sig_en, cur_cfg.edit,
                       cur_cfg.echo, cur_cfg.quote_en, cur_cfg.term_en};
  // Bits 2 and 0 are left out of the toggle word
  assign next_flags = base_flags ^ {cmd.subfn[7:3], cmd.subfn[1]};
  always_comb begin
    next_status = '0;
    next_cfg    = cur_cfg;
    cfg_write   = 1'b0;
    map_write   = 1'b0;
    card_write  = 1'b0;
    go_read     = 1'b0;
    go_write    = 1'b0;
    go_ctrl     = 1'b0;
    case (req_code_t'(cmd.code))
      REQ_IDENTIFY: begin
        next_status.kind     = ANS_IDENT;
        next_status.answer_a = MULTIPLEX_CAPABILITY;
        next_status.answer_b = TRANSFER_WIDTH_CAPABILITY;
      end
      REQ_READ_DATA: begin
        if (!port_hit) next_status.req_status = ST_ILLEGAL_PORT;
        else go_read = 1'b1;
      end
      REQ_WRITE_DATA: begin
        if (!port_hit) next_status.req_status = ST_ILLEGAL_PORT;
        else go_write = 1'b1;
      end
      REQ_CONTROL: begin
        if (!port_hit) next_status.req_status = ST_ILLEGAL_PORT;
        else if (cmd.subfn > CTRL_LAST) next_status.req_status = ST_ILLEGAL_SUBFN;
        else go_ctrl = 1'b1;
      end
      REQ_READ_STATUS: begin
        next_status.answer_a = {5'h00, phys};
        case (cmd.subfn)
          SF_RX_STATUS:   next_status.kind = ANS_RX_STATUS;
          SF_CARD_STATUS: next_status.kind = ANS_CARD_STATUS;
          SF_CARD_MEM: begin
            next_status.kind     = ANS_CARD_MEM;
            next_status.answer_a = card_reg;
          end
          default: next_status.req_status = ST_ILLEGAL_SUBFN;
        endcase
      end
      REQ_WRITE_CONFIG: begin
        // Card register ignores the port field; a security code guards it
        if (cmd.subfn == SF_CARD_WRITE) begin
          if (data_q[15:8] == CARD_KEY) card_write = 1'b1;
          else next_status.req_status = ST_ILLEGAL_VALUE;
        end else if (cmd.subfn == SF_PORT_ID) begin
          if (data_q[31:3] == 29'h0) map_write = 1'b1;
          else next_status.req_status = ST_ILLEGAL_VALUE;
        end else if (!port_hit) begin
          next_status.req_status = ST_ILLEGAL_PORT;
        end else begin
          cfg_write = 1'b1;
          case (cmd.subfn)
            SF_ALL: begin
              next_cfg.baud      = data_q[7:0];
              next_cfg.char_len  = data_q[11:8];
              next_cfg.stop_bits = data_q[13:12];
              next_cfg.parity    = data_q[15:14];
              next_cfg.int_mask  = data_q[23:16];
              next_cfg.eoc_len   = data_q[31:24];
            end
            SF_READ_OPT: {next_cfg.quote_en, next_cfg.edit, next_cfg.echo, next_cfg.sig_en,
                          next_cfg.eoc_en, next_cfg.term_en} = data_q[5:0];
            SF_EOC_LEN:   next_cfg.eoc_len = data_q[7:0];
            SF_ALERT:     next_cfg = cur_cfg;
            SF_DUPLEX:    next_cfg.full_duplex = data_q[0];
            SF_BS:        next_cfg.bs_char = data_q[7:0];
            SF_DEL:       next_cfg.del_char = data_q[7:0];
            SF_OTHER:     {next_cfg.bs_echo, next_cfg.crlf_en, next_cfg.term_echo, next_cfg.strip} = data_q[3:0];
            SF_HSHAKE:    {next_cfg.char_hs_en, next_cfg.enq_en, next_cfg.host_xon_en,
                           next_cfg.dev_xon_en} = data_q[3:0];
            SF_BAUD:      next_cfg.baud = data_q[7:0];
            SF_CHAR_LEN: begin
              if (data_q[3:0] < CHAR_LEN_MIN || data_q[3:0] > CHAR_LEN_MAX) begin
                cfg_write              = 1'b0;
                next_status.req_status = ST_ILLEGAL_VALUE;
              end
              next_cfg.char_len = data_q[3:0];
            end
            SF_STOP:      next_cfg.stop_bits = data_q[1:0];
            SF_PARITY:    next_cfg.parity = data_q[1:0];
            SF_HS_TIMER:  next_cfg.ack_timer = data_q[7:0];
            SF_INT_MASK:  next_cfg.int_mask = data_q[7:0];
            SF_HOST_XON:  {next_cfg.host_xoff, next_cfg.host_xon} = data_q[15:0];
            SF_DEV_XON:   {next_cfg.dev_xoff, next_cfg.dev_xon} = data_q[15:0];
            SF_ENQ_ACK:   {next_cfg.ack_char, next_cfg.enq_char} = data_q[15:0];
            SF_PACING:    next_cfg.pacing = data_q[7:0];
            SF_CRLF_TERM: next_cfg.crlf_char = data_q[7:0];
            SF_SEPARATOR: begin
              if (data_q[17:16] == 2'h0 || data_q[17:16] > SEP_COUNT_DEF) begin
                cfg_write              = 1'b0;
                next_status.req_status = ST_ILLEGAL_LEN;
              end
              {next_cfg.sep1, next_cfg.sep0} = data_q[15:0];
              next_cfg.sep_count             = data_q[17:16];
            end
            SF_ADD_OPT: begin
              {next_cfg.null_brk, next_cfg.cond_sep} = data_q[1:0];
              next_cfg.rec_sep    = data_q[15:8];
              next_cfg.bad_char   = data_q[23:16];
              next_cfg.quote_char = data_q[31:24];
            end
            SF_TERM: begin
              if (data_q[11:8] == 4'h0 || data_q[11:8] > TERM_COUNT_MAX) begin
                cfg_write              = 1'b0;
                next_status.req_status = ST_ILLEGAL_LEN;
              end
              next_cfg.term_char  = data_q[7:0];
              next_cfg.term_count = data_q[11:8];
            end
            default: begin
              cfg_write              = 1'b0;
              next_status.req_status = ST_ILLEGAL_SUBFN;
            end
          endcase
        end
      end
      default: next_status.req_status = ST_ILLEGAL_REQ;
    endcase
  end
  // ==========================================================
  // Per-port configuration store
  // Async reset loads constants only, so defaults hold before any request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        cfg[i]      <= CFG_DEFAULT;
        port_map[i] <= PORT_W'(i);
      end
    end else begin
      if (exec && cfg_write) begin
        cfg[phys] <= next_cfg;
      end
      if (exec && map_write) begin
        port_map[data_q[2:0]] <= cmd.port;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      card_reg <= 8'h00;
    end else if (exec && card_write) begin
      card_reg <= data_q[7:0];
    end
  end
  // ==========================================================
  // Software registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q   <= 32'h00000000;
      sel_port <= 3'h0;
      sel_word <= 3'h0;
    end else if (wr_phase && wr_addr == OFS_DATA) begin
      data_q <= hwdata;
    end else if (wr_phase && wr_addr == OFS_CFG_SEL) begin
      sel_port <= hwdata[2:0];
      sel_word <= hwdata[6:4];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= '0;
    end else if (exec) begin
      status_q <= next_status;
    end
  end
  // ==========================================================
  // Request strobes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_valid      <= 1'b0;
      read_port       <= 3'h0;
      read_flags      <= 6'h00;
      write_valid     <= 1'b0;
      write_port      <= 3'h0;
      write_append    <= 1'b0;
      write_sep_count <= 2'h0;
      write_sep_chars <= 16'h0000;
      ctrl_valid      <= 1'b0;
      ctrl_port       <= 3'h0;
      ctrl_action     <= 4'h0;
    end else begin
      read_valid  <= exec && go_read;
      write_valid <= exec && go_write;
      ctrl_valid  <= exec && go_ctrl;
      if (exec && go_read) begin
        read_port  <= phys;
        read_flags <= next_flags;
      end
      if (exec && go_write) begin
        write_port      <= phys;
        write_append    <= cmd.subfn[0];
        write_sep_count <= cur_cfg.sep_count;
        write_sep_chars <= {cur_cfg.sep1, cur_cfg.sep0};
      end
      if (exec && go_ctrl) begin
        ctrl_port   <= phys;
        ctrl_action <= cmd.subfn[3:0];
      end
    end
  end
  // ==========================================================
  // Read mux, data registered in the address phase
  assign cfg_bits = 256'(cfg[sel_port]);
  always_comb begin
    rd_value = 32'h00000000;
    if (haddr[31:8] == 24'h000000) begin
      case (haddr[7:0])
        OFS_DATA:    rd_value = data_q;
        OFS_STATUS:  rd_value = status_q;
        OFS_CFG_SEL: rd_value = {25'h0, sel_word, 1'b0, sel_port};
        OFS_CFG_RD:  rd_value = cfg_bits[{sel_word, 5'h00} +: 32];
        OFS_IDENT:   rd_value = {16'h0000, TRANSFER_WIDTH_CAPABILITY, MULTIPLEX_CAPABILITY};
        OFS_CARD:    rd_value = {24'h000000, card_reg};
        OFS_PORTMAP: begin
          for (int i = 0; i < NUM_PORTS; i++) begin
            rd_value[i*4 +: 4] = {1'b0, port_map[i]};
          end
        end
        default:     rd_value = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_value;
    end
  end
  // ==========================================================
  // Checks
  logic settled;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) settled <= 1'b0;
    else          settled <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_read_req;
    exec && req_code_t'(cmd.code) == REQ_READ_DATA && port_hit;
  endsequence
  sequence s_ctrl_req;
    exec && req_code_t'(cmd.code) == REQ_CONTROL && port_hit;
  endsequence
  AST_DEFAULTS: assert property (!settled |-> cfg[0] == CFG_DEFAULT && cfg[7] == CFG_DEFAULT)
    else $error("port configuration not at defaults after reset");
  AST_IDENT_CAPS: assert property (exec && req_code_t'(cmd.code) == REQ_IDENTIFY |=>
    status_q.answer_a == 8'h01 && status_q.answer_b == 8'h02 && status_q.req_status == 8'h00)
    else $error("identify answer wrong");
  AST_READ_TOGGLE: assert property (s_read_req ##1 read_valid |->
    read_flags[5] == ($past(cur_cfg.char_hs_en) ^ $past(hwdata[7])) &&
    read_flags[0] == ($past(cur_cfg.term_en) ^ $past(hwdata[1])))
    else $error("read toggle bits misapplied");
  AST_RESERVED_BITS: assert property (s_read_req |=> read_valid &&
    read_flags[4:1] == ($past(base_flags[4:1]) ^ $past(hwdata[6:3])))
    else $error("reserved read bits changed a mode");
  AST_APPEND: assert property (exec && req_code_t'(cmd.code) == REQ_WRITE_DATA && port_hit |=>
    write_valid && write_append == $past(hwdata[0]) && !read_valid)
    else $error("separator append not following bit 0");
  AST_CTRL_DECODE: assert property ((s_ctrl_req and (cmd.subfn <= 8'h08)) |=>
    ctrl_valid && ctrl_action == $past(hwdata[3:0]) ##1 !ctrl_valid)
    else $error("control subfunction not decoded");
  AST_BAD_SUBFN: assert property ((s_ctrl_req and (cmd.subfn > 8'h08)) |=>
    !ctrl_valid && status_q.req_status == 8'h01)
    else $error("unknown control subfunction not refused");
  AST_STATUS_CODES: assert property (exec && req_code_t'(cmd.code) == REQ_READ_STATUS &&
    cmd.subfn == 8'hF9 |=> status_q.kind == ANS_RX_STATUS && status_q.req_status == 8'h00)
    else $error("receive status request not answered");
  AST_OTHER_PORT: assert property (exec && cfg_write && phys != 3'h0 |=> $stable(cfg[0]))
    else $error("configuration of another port changed");
  AST_BAUD_WRITE: assert property (exec && cfg_write && cmd.subfn == 8'h0A |=>
    cfg[$past(phys)].baud == $past(data_q[7:0]))
    else $error("baud rate subfunction not applied");
endmodule : serial_mux_command_config

//--- serial_mux_pkg.sv
package serial_mux_pkg;
  // ==========================================================
  // Sizes and register offsets
  localparam int         NUM_PORTS   = 8;
  localparam int         PORT_W      = 3;
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_DATA    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_CFG_SEL = 8'h0C;
  localparam logic [7:0] OFS_CFG_RD  = 8'h10;
  localparam logic [7:0] OFS_IDENT   = 8'h14;
  localparam logic [7:0] OFS_CARD    = 8'h18;
  localparam logic [7:0] OFS_PORTMAP = 8'h1C;
  // ==========================================================
  // Characters and default values
  localparam logic [7:0] CH_EOT = 8'h04, CH_ENQ = 8'h05, CH_ACK = 8'h06, CH_BS = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0A, CH_CR = 8'h0D, CH_DC1 = 8'h11, CH_DC3 = 8'h13;
  localparam logic [7:0] CH_BSLASH = 8'h5C, CH_DEL = 8'h7F, CH_SIG_NONE = 8'hFF;
  localparam logic [7:0] BAUD_9600        = 8'h0E;
  localparam logic [7:0] EOC_LEN_DEFAULT  = 8'hFC;
  localparam logic [7:0] PACING_DEFAULT   = 8'h50;
  localparam logic [7:0] ACK_TIMER_SEC    = 8'h05;
  localparam logic [3:0] CHAR_LEN_MIN     = 4'h5;
  localparam logic [3:0] CHAR_LEN_MAX     = 4'h8;
  localparam logic [1:0] STOP_DEFAULT     = 2'h1;
  localparam logic [1:0] PARITY_NONE      = 2'h0;
  localparam logic [1:0] SEP_COUNT_DEF    = 2'h2;
  localparam logic [3:0] TERM_COUNT_DEF   = 4'h1;
  localparam logic [3:0] TERM_COUNT_MAX   = 4'h8;
  localparam logic [7:0] CARD_KEY_DEFAULT = 8'hA5;
  localparam logic [7:0] MULTIPLEX_CAPABILITY      = 8'h01;
  localparam logic [7:0] TRANSFER_WIDTH_CAPABILITY = 8'h02;
  // ==========================================================
  // Subfunction and status codes
  localparam logic [7:0] SF_ALL = 8'h00, SF_READ_OPT = 8'h01, SF_EOC_LEN = 8'h02, SF_ALERT = 8'h03;
  localparam logic [7:0] SF_DUPLEX = 8'h05, SF_BS = 8'h06, SF_DEL = 8'h07, SF_OTHER = 8'h08;
  localparam logic [7:0] SF_HSHAKE = 8'h09, SF_BAUD = 8'h0A, SF_CHAR_LEN = 8'h0B, SF_STOP = 8'h0C;
  localparam logic [7:0] SF_PARITY = 8'h0D, SF_HS_TIMER = 8'h12, SF_INT_MASK = 8'h15, SF_HOST_XON = 8'h16;
  localparam logic [7:0] SF_DEV_XON = 8'h17, SF_ENQ_ACK = 8'h18, SF_PACING = 8'h19, SF_CRLF_TERM = 8'h1B;
  localparam logic [7:0] SF_SEPARATOR = 8'h1C, SF_ADD_OPT = 8'h1F, SF_TERM = 8'h20, SF_CARD_WRITE = 8'h21;
  localparam logic [7:0] SF_PORT_ID = 8'h22, SF_RX_STATUS = 8'hF9, SF_CARD_MEM = 8'hFA, SF_CARD_STATUS = 8'hFE;
  localparam logic [7:0] CTRL_LAST = 8'h08;
  localparam logic [7:0] ST_OK = 8'h00, ST_ILLEGAL_SUBFN = 8'h01, ST_ILLEGAL_VALUE = 8'h02;
  localparam logic [7:0] ST_ILLEGAL_LEN = 8'h03, ST_ILLEGAL_REQ = 8'h04, ST_ILLEGAL_PORT = 8'h05;
  localparam logic [7:0] ANS_NONE = 8'h00, ANS_IDENT = 8'h01, ANS_RX_STATUS = 8'h02;
  localparam logic [7:0] ANS_CARD_MEM = 8'h03, ANS_CARD_STATUS = 8'h04;
  typedef enum logic [3:0] {
    REQ_IDENTIFY = 4'h1, REQ_READ_DATA = 4'h2, REQ_WRITE_DATA = 4'h3,
    REQ_WRITE_CONFIG = 4'h4, REQ_CONTROL = 4'h5, REQ_READ_STATUS = 4'h6
  } req_code_t;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [11:0] pad_hi; logic [3:0] code; logic [4:0] pad_lo; logic [2:0] port; logic [7:0] subfn;
  } cmd_word_t;
  typedef struct packed {
    logic [7:0] answer_b; logic [7:0] answer_a; logic [7:0] kind; logic [7:0] req_status;
  } status_word_t;
  typedef struct packed {
    logic [7:0] baud; logic [3:0] char_len; logic [1:0] stop_bits, parity;
    logic eoc_en, enq_en, cond_sep, sig_en, term_en, strip, term_echo, crlf_en;
    logic echo, edit, full_duplex, bs_echo, dev_xon_en, host_xon_en, quote_en, null_brk, char_hs_en;
    logic [7:0] eoc_len, pacing, ack_timer, int_mask, sep0, sep1, rec_sep, term_char, quote_term;
    logic [7:0] crlf_char, bs_char, del_char, host_xon, host_xoff, dev_xon, dev_xoff, enq_char;
    logic [7:0] ack_char, bad_char, quote_char;
    logic [1:0] sep_count; logic [3:0] term_count; logic [31:0] sig_chars;
  } cfg_t;
  localparam cfg_t CFG_DEFAULT = '{
    baud: BAUD_9600, char_len: CHAR_LEN_MAX, stop_bits: STOP_DEFAULT, parity: PARITY_NONE,
    eoc_en: 1'b0, eoc_len: EOC_LEN_DEFAULT,
    enq_en: 1'b0, pacing: PACING_DEFAULT, ack_timer: ACK_TIMER_SEC, enq_char: CH_ENQ, ack_char: CH_ACK,
    int_mask: 8'h00,
    sep_count: SEP_COUNT_DEF, sep0: CH_CR, sep1: CH_LF, cond_sep: 1'b0, rec_sep: CH_LF,
    sig_en: 1'b0, sig_chars: {4{CH_SIG_NONE}},
    term_en: 1'b0, term_count: TERM_COUNT_DEF, term_char: CH_CR, strip: 1'b1,
    term_echo: 1'b0, quote_term: CH_EOT,
    crlf_en: 1'b1, crlf_char: CH_CR, echo: 1'b0, edit: 1'b0,
    full_duplex: 1'b1, bs_char: CH_BS, del_char: CH_DEL, bs_echo: 1'b1,
    dev_xon_en: 1'b0, host_xon_en: 1'b0, host_xon: CH_DC1, host_xoff: CH_DC3,
    dev_xon: CH_DC1, dev_xoff: CH_DC3, char_hs_en: 1'b0,
    bad_char: CH_DEL, quote_en: 1'b0, quote_char: CH_BSLASH, null_brk: 1'b0
  };
endpackage : serial_mux_pkg

//--- host_model.sv
`timescale 1ns/1ps
// ==========
// Host side bus master
module host_model (
  // Clock
  input  wire logic        sys_clk,
  // Bus answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // Select stays high, so back-to-back calls never drive it twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : host_model

//--- serial_mux_command_config_bench.sv
`timescale 1ns/1ps
// ==========
// Command interpreter bench
module serial_mux_command_config_bench;
  import serial_mux_pkg::*;
  typedef struct packed { logic [31:0] cmd, data; logic [15:0] st; } row_t;
  logic        sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, read_valid, write_valid, write_append, ctrl_valid;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, write_sep_count;
  logic [2:0]  hsize, read_port, write_port, ctrl_port;
  logic [5:0]  read_flags;
  logic [15:0] write_sep_chars;
  logic [3:0]  ctrl_action;
  logic [7:0]  card_reg, s;
  int          num_errors, n_compared, cyc;
  cfg_t        c;
  // Command, parameter word, expected {answer kind, request status}
  row_t rows[16] = '{
    '{32'h0001_0000, 32'h0, 16'h0100},
    '{32'h0006_00F9, 32'h0, 16'h0200},
    '{32'h0006_00FA, 32'h0, 16'h0300},
    '{32'h0006_00FE, 32'h0, 16'h0400},
    '{32'h0006_00FB, 32'h0, 16'h0001},
    '{32'h0004_0004, 32'h0, 16'h0001},
    '{32'h0004_0023, 32'h0, 16'h0001},
    '{32'h0004_010B, 32'h9, 16'h0002},
    '{32'h0005_0009, 32'h0, 16'h0001},
    '{32'h0007_0000, 32'h0, 16'h0004},
    '{32'h0004_0022, 32'h8, 16'h0002},
    '{32'h0004_001C, 32'h0003_0D0A, 16'h0003},
    '{32'h0004_0020, 32'h90D, 16'h0003},
    '{32'h0004_0003, 32'h0, 16'h0000},
    '{32'h0004_0021, 32'h0000_1111, 16'h0002},
    '{32'h0004_0021, {16'h0, CARD_KEY_DEFAULT, 8'h3C}, 16'h0000}
  };
  host_model host_model_inst (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  serial_mux_command_config serial_mux_command_config_inst (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .read_valid(read_valid), .read_port(read_port),
    .read_flags(read_flags), .write_valid(write_valid), .write_port(write_port), .write_append(write_append),
    .write_sep_count(write_sep_count), .write_sep_chars(write_sep_chars), .ctrl_valid(ctrl_valid),
    .ctrl_port(ctrl_port), .ctrl_action(ctrl_action), .card_reg(card_reg));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic cmd(input logic [31:0] d, input logic [31:0] k);
    host_model_inst.xfer(1'b1, OFS_DATA, d, r);
    host_model_inst.xfer(1'b1, OFS_CMD, k, r);
    @(posedge sys_clk);
  endtask : cmd
  // Gathers all words of one port's settings; slow but independent of field layout
  task automatic rdcfg(input logic [2:0] p);
    logic [255:0] v;
    for (int w = 0; w < 8; w++) begin
      host_model_inst.xfer(1'b1, OFS_CFG_SEL, {25'h0, w[2:0], 1'b0, p}, r);
      host_model_inst.xfer(1'b0, OFS_CFG_RD, 32'h0, v[32*w +: 32]);
    end
    c = cfg_t'(v[$bits(cfg_t)-1:0]);
  endtask : rdcfg
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(hreadyout, 1'b0);
    reset_n <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    reset_n = 1'b0;
    cyc = 0;
    do_reset();
    for (int p = 0; p < 8; p++) begin
      rdcfg(p[2:0]);
      chk(c, CFG_DEFAULT);
    end
    chk({c.baud, c.char_len, c.stop_bits, c.parity}, {BAUD_9600, 4'h8, 2'h1, 2'h0});
    chk({c.eoc_en, c.eoc_len}, {1'b0, 8'hFC});
    chk({c.enq_en, c.pacing, c.ack_timer}, {1'b0, 8'h50, 8'h05});
    chk({c.sig_en, c.sig_chars}, {1'b0, 32'hFFFF_FFFF});
    chk(c.int_mask, 8'h00);
    chk({c.sep_count, c.sep0, c.sep1, c.cond_sep, c.rec_sep}, {2'h2, CH_CR, CH_LF, 1'b0, CH_LF});
    chk({c.term_count, c.term_char, c.strip, c.term_echo, c.quote_term}, {4'h1, CH_CR, 2'b10, CH_EOT});
    chk({c.crlf_en, c.crlf_char, c.echo, c.edit}, {1'b1, CH_CR, 2'b00});
    chk({c.full_duplex, c.bs_char, c.del_char, c.bs_echo}, {1'b1, CH_BS, CH_DEL, 1'b1});
    chk({c.dev_xon_en, c.host_xon_en, c.host_xon, c.host_xoff, c.dev_xon, c.dev_xoff},
        {2'b00, CH_DC1, CH_DC3, CH_DC1, CH_DC3});
    chk({c.bad_char, c.quote_en, c.quote_char, c.null_brk}, {CH_DEL, 1'b0, CH_BSLASH, 1'b0});
    foreach (rows[i]) begin
      cmd(rows[i].data, rows[i].cmd);
      host_model_inst.xfer(1'b0, OFS_STATUS, 32'h0, r);
      chk({hresp, r[15:0]}, {1'b0, rows[i].st});
    end
    chk(card_reg, 8'h3C);
    host_model_inst.xfer(1'b0, OFS_IDENT, 32'h0, r);
    chk(r[15:0], {TRANSFER_WIDTH_CAPABILITY, 8'h01});
    for (int i = 0; i < 8; i++) begin
      s = 8'h01 << i;
      cmd(32'h0, {16'h0002, 8'h01, s});
      chk({read_valid, read_port, read_flags}, {1'b1, 3'h1, s[7:3], s[1]});
    end
    for (int i = 0; i < 2; i++) begin
      cmd(32'h0, {16'h0003, 8'h02, 7'h0, i[0]});
      chk({write_valid, write_port, write_append, write_sep_count, write_sep_chars}, {4'hA, i[0], 18'h20A0D});
    end
    for (int i = 0; i < 9; i++) begin
      cmd(32'h0, {16'h0005, 8'h03, 4'h0, i[3:0]});
      chk({ctrl_valid, ctrl_port, ctrl_action}, {1'b1, 3'h3, i[3:0]});
    end
    cmd(32'h1077_570A, 32'h0004_0500);
    rdcfg(3'h5);
    chk({c.baud, c.char_len, c.stop_bits, c.parity, c.int_mask, c.eoc_len}, 32'h0A75_7710);
    rdcfg(3'h4);
    chk(c, CFG_DEFAULT);
    do_reset();
    rdcfg(3'h5);
    chk(c, CFG_DEFAULT);
    test_done();
  end
endmodule : serial_mux_command_config_bench
